// ==== rtl/irq_latch_pkg.sv ====
/*
  Constants for the interrupt latch and enable unit: register offsets,
  field positions, reset values and sequencing counts.
  Assumes an APB slave with 32-bit data, one byte register per word.
*/
package irq_latch_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_ENABLE_BYTE_E      = 8'h2a;
  localparam logic [7:0] IDX_LATCH_BYTE_C       = 8'h2b;
  localparam logic [7:0] IDX_ENABLE_BYTE_C      = 8'h2c;
  localparam logic [7:0] IDX_ENABLE_BYTE_D      = 8'h2d;
  localparam logic [7:0] IDX_LATCH_BYTE_E       = 8'h2e;
  localparam logic [7:0] IDX_LATCH_BYTE_D       = 8'h2f;
  localparam logic [7:0] IDX_ENABLE_LOW_MASTER  = 8'h3a;
  localparam logic [7:0] IDX_ENABLE_HIGH_BYTE   = 8'h3b;
  localparam logic [7:0] IDX_LATCH_LOW_BYTE     = 8'h3c;
  localparam logic [7:0] IDX_LATCH_HIGH_NESTING = 8'h3d;
  // Status register of own choosing: software-request flag, selected source
  localparam logic [7:0] IDX_SERVICE_STATUS     = 8'h3e;

  // Source numbering
  localparam int NUM_SRC       = 40;
  localparam int SRC_WATCHDOG  = 2;
  localparam int FIRST_MASKABLE = 3;

  // Field positions
  localparam int MASTER_ENABLE_BIT = 0;
  localparam int NESTING_LSB       = 6; // nesting field in latch_high_nesting bits 7:6

  // Nesting field write codes
  localparam logic [1:0] NEST_WR_CLEAR = 2'b01;
  localparam logic [1:0] NEST_WR_DEC   = 2'b10;

  // Reset values
  localparam logic [39:0] PENDING_RESET = 40'h00_0000_0000;
  localparam logic [39:0] ENABLE_RESET  = 40'h00_0000_0000;
  localparam logic [3:0]  NEST_RESET    = 4'h0;

  // Acceptance sequence length in machine cycles
  localparam int ACCEPT_MACHINE_CYCLES = 12;

endpackage : irq_latch_pkg

// ==== rtl/nested_interrupt_latch_enable_unit.sv ====
/*
  Interrupt request latching, enabling, priority selection and nesting
  depth tracking, with an APB register window.
  Assumes: ref_clk_i at 125 MHz; request lines and sequencer strobes are
  synchronous one-cycle pulses; mach_cycle_en_i marks machine cycles.
*/
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module nested_interrupt_latch_enable_unit
  import irq_latch_pkg::*;
#(
  parameter int NEST_W = 4
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_n_i,
  // APB slave
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [11:0]                paddr_i,
  input  wire logic [31:0]                pwdata_i,
  input  wire logic [3:0]                 pstrb_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  // Request sources and sequencer
  input  wire logic [irq_latch_pkg::NUM_SRC-1:0] src_request_i,
  input  wire logic                       software_request_i,
  input  wire logic                       instr_end_i,
  input  wire logic                       mach_cycle_en_i,
  input  wire logic                       unmask_all_instr_i,
  input  wire logic                       mask_all_instr_i,
  input  wire logic                       maskable_return_i,
  input  wire logic                       nonmaskable_return_i,
  output logic                            irq_request_o,
  output logic                            accept_busy_o,
  output logic                            accept_done_o,
  output logic      [5:0]                 accept_src_o,
  output logic                            saved_master_o
);

  typedef enum logic [0:0] {ST_IDLE, ST_ACCEPT} accept_state_e;

  logic [NUM_SRC-1:0] pending_latch_reg;
  logic [NUM_SRC-1:0] source_enable_reg;
  logic               master_enable_reg;
  logic [NEST_W-1:0]  nesting_reg;
  logic               nm_saved_reg;
  accept_state_e      state_reg;
  logic [3:0]         mcycle_reg;
  logic [5:0]         sel_src_reg;
  logic               sel_sw_reg;

  logic [NUM_SRC-1:0] eligible;
  logic               sel_valid;
  logic [5:0]         sel_src;
  logic [NUM_SRC-1:0] wr_clear;
  logic               apb_wr;
  logic               apb_rd;
  logic [7:0]         reg_idx;
  logic               addr_hit;
  logic [7:0]         wbyte;
  logic               start_accept;
  logic               accept_fire;
  logic [1:0]         nest_field;

  // Simple zero-wait slave; write lane 0 carries the byte
  assign apb_wr   = psel_i && penable_i && pwrite_i;
  assign apb_rd   = psel_i && penable_i && !pwrite_i;
  assign reg_idx  = paddr_i[9:2];
  assign wbyte    = pstrb_i[0] ? pwdata_i[7:0] : 8'hff;
  assign pready_o = 1'b1;

  // Mapped offsets
  always_comb begin
    case (reg_idx)
      IDX_ENABLE_BYTE_E, IDX_LATCH_BYTE_C, IDX_ENABLE_BYTE_C, IDX_ENABLE_BYTE_D,
      IDX_LATCH_BYTE_E, IDX_LATCH_BYTE_D, IDX_ENABLE_LOW_MASTER,
      IDX_ENABLE_HIGH_BYTE, IDX_LATCH_LOW_BYTE, IDX_LATCH_HIGH_NESTING,
      IDX_SERVICE_STATUS: addr_hit = (paddr_i[1:0] == 2'b00) && (paddr_i[11:10] == 2'b00);
      default: addr_hit = 1'b0;
    endcase
  end
  assign pslverr_o = psel_i && penable_i && !addr_hit;

  // Nesting depth as the two-bit field
  always_comb begin
    if (nesting_reg == '0) begin
      nest_field = 2'b00;
    end else if (nesting_reg == NEST_W'(1)) begin
      nest_field = 2'b01;
    end else if (nesting_reg == NEST_W'(2)) begin
      nest_field = 2'b10;
    end else begin
      nest_field = 2'b11;
    end
  end

  // Write-zero clears per latch byte; bit 1 of the low byte is unused
  always_comb begin
    wr_clear = '0;
    if (apb_wr) begin
      case (reg_idx)
        IDX_LATCH_LOW_BYTE: begin
          wr_clear[7:0] = ~wbyte;
        end
        IDX_LATCH_HIGH_NESTING: begin
          wr_clear[13:8] = ~wbyte[5:0];
        end
        IDX_LATCH_BYTE_E: begin
          wr_clear[23:16] = ~wbyte;
        end
        IDX_LATCH_BYTE_D: begin
          wr_clear[31:24] = ~wbyte;
        end
        IDX_LATCH_BYTE_C: begin
          wr_clear[39:32] = ~wbyte;
        end
        default: begin
          wr_clear = '0;
        end
      endcase
    end
    wr_clear[SRC_WATCHDOG] = 1'b0; // Watchdog never cleared by a write
  end

  // Eligibility: pseudo non-maskable bypass, maskable gated
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_elig
      if (g == SRC_WATCHDOG) begin : g_nm
        assign eligible[g] = pending_latch_reg[g];
      end else if (g < FIRST_MASKABLE) begin : g_none
        assign eligible[g] = 1'b0;
      end else begin : g_mask
        assign eligible[g] = pending_latch_reg[g] && source_enable_reg[g]
                             && master_enable_reg;
      end
    end
  endgenerate

  // Lowest number wins; software request outranks all latched sources
  always_comb begin
    sel_valid = 1'b0;
    sel_src   = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        sel_valid = 1'b1;
        sel_src   = 6'(i);
      end
    end
  end

  assign irq_request_o = sel_valid || software_request_i;
  // Requests sampled on the final cycle of an instruction
  assign start_accept  = (state_reg == ST_IDLE) && instr_end_i
                         && (sel_valid || software_request_i);
  assign accept_fire   = (state_reg == ST_ACCEPT) && mach_cycle_en_i
                         && (mcycle_reg == 4'(ACCEPT_MACHINE_CYCLES - 1));

  // Acceptance sequencer; source is frozen at its start
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg   <= ST_IDLE;
      mcycle_reg  <= '0;
      sel_src_reg <= '0;
      sel_sw_reg  <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          mcycle_reg <= '0;
          if (start_accept) begin
            state_reg   <= ST_ACCEPT;
            sel_sw_reg  <= software_request_i;
            sel_src_reg <= software_request_i ? 6'd1 : sel_src;
          end
        end
        ST_ACCEPT: begin
          if (mach_cycle_en_i) begin
            mcycle_reg <= mcycle_reg + 4'd1;
            if (accept_fire) begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Latches: hardware set wins over any clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending_latch_reg <= PENDING_RESET;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (src_request_i[i] && i >= SRC_WATCHDOG) begin
          pending_latch_reg[i] <= 1'b1;
        end else if (start_accept && !software_request_i && sel_src == 6'(i)) begin
          pending_latch_reg[i] <= 1'b0;
        end else if (wr_clear[i]) begin
          pending_latch_reg[i] <= 1'b0;
        end // Otherwise held
      end
    end
  end

  // Enable bits, writable any way software likes
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      source_enable_reg <= ENABLE_RESET;
    end else if (apb_wr) begin
      case (reg_idx)
        IDX_ENABLE_LOW_MASTER: source_enable_reg[7:3]   <= wbyte[7:3];
        IDX_ENABLE_HIGH_BYTE:  source_enable_reg[15:8]  <= wbyte;
        IDX_ENABLE_BYTE_E:     source_enable_reg[23:16] <= wbyte;
        IDX_ENABLE_BYTE_D:     source_enable_reg[31:24] <= wbyte;
        IDX_ENABLE_BYTE_C:     source_enable_reg[39:32] <= wbyte;
        default:               source_enable_reg        <= source_enable_reg;
      endcase
    end
  end

  // Master enable: acceptance beats returns, instructions, writes
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      master_enable_reg <= 1'b0;
      nm_saved_reg      <= 1'b0;
    end else if (start_accept) begin
      nm_saved_reg      <= master_enable_reg; // Saved before clearing
      master_enable_reg <= 1'b0;
    end else if (maskable_return_i) begin
      master_enable_reg <= 1'b1;
    end else if (nonmaskable_return_i) begin
      master_enable_reg <= nm_saved_reg; // Restores the value saved at acceptance
    end else if (unmask_all_instr_i) begin
      master_enable_reg <= 1'b1;
    end else if (mask_all_instr_i) begin
      master_enable_reg <= 1'b0;
    end else if (apb_wr && reg_idx == IDX_ENABLE_LOW_MASTER) begin
      master_enable_reg <= wbyte[MASTER_ENABLE_BIT];
    end
  end

  // Saved flag travels to the stacked status word
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      saved_master_o <= 1'b0;
      accept_src_o   <= '0;
    end else if (start_accept) begin
      saved_master_o <= master_enable_reg;
      accept_src_o   <= software_request_i ? 6'd1 : sel_src;
    end
  end

  assign accept_busy_o = (state_reg == ST_ACCEPT);
  assign accept_done_o = accept_fire;

  // Nesting counter wraps silently on underflow
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nesting_reg <= NEST_RESET[NEST_W-1:0];
    end else if (start_accept) begin
      nesting_reg <= nesting_reg + NEST_W'(1);
    end else if (maskable_return_i || nonmaskable_return_i) begin
      nesting_reg <= nesting_reg - NEST_W'(1);
    end else if (apb_wr && reg_idx == IDX_LATCH_HIGH_NESTING) begin
      case (wbyte[NESTING_LSB +: 2])
        NEST_WR_CLEAR: nesting_reg <= '0;
        NEST_WR_DEC:   nesting_reg <= nesting_reg - NEST_W'(1);
        default:       nesting_reg <= nesting_reg;
      endcase
    end
  end

  // Read data registered on the access phase
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= '0;
    end else if (apb_rd) begin
      case (reg_idx)
        IDX_LATCH_LOW_BYTE:     prdata_o <= {24'h0, pending_latch_reg[7:0]};
        IDX_LATCH_HIGH_NESTING: prdata_o <= {24'h0, nest_field,
                                             pending_latch_reg[13:8]};
        IDX_LATCH_BYTE_E:       prdata_o <= {24'h0, pending_latch_reg[23:16]};
        IDX_LATCH_BYTE_D:       prdata_o <= {24'h0, pending_latch_reg[31:24]};
        IDX_LATCH_BYTE_C:       prdata_o <= {24'h0, pending_latch_reg[39:32]};
        IDX_ENABLE_LOW_MASTER:  prdata_o <= {24'h0, source_enable_reg[7:3], 2'b00,
                                             master_enable_reg};
        IDX_ENABLE_HIGH_BYTE:   prdata_o <= {24'h0, source_enable_reg[15:8]};
        IDX_ENABLE_BYTE_E:      prdata_o <= {24'h0, source_enable_reg[23:16]};
        IDX_ENABLE_BYTE_D:      prdata_o <= {24'h0, source_enable_reg[31:24]};
        IDX_ENABLE_BYTE_C:      prdata_o <= {24'h0, source_enable_reg[39:32]};
        IDX_SERVICE_STATUS:     prdata_o <= {16'h0, 2'b00, sel_src_reg, 7'h0,
                                             sel_sw_reg};
        default:                prdata_o <= '0;
      endcase
    end
  end

endmodule : nested_interrupt_latch_enable_unit

`default_nettype wire

// ==== test/irq_cpu_model.sv ====
/*
  CPU sequencer stand-in: machine-cycle strobes and instruction ends.
  Assumes the unit's busy flag is fed back so no instruction ends
  while an acceptance sequence runs.
*/
`timescale 1ns/1ps
`default_nettype none

module irq_cpu_model (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic accept_busy_i,
  output logic      mach_cycle_en_o,
  output logic      instr_end_o
);
  logic [3:0] phase_reg;

  // Four clocks a machine cycle, four machine cycles an instruction
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) phase_reg <= 4'h0;
    else phase_reg <= phase_reg + 4'h1;
  end

  // Slow strobes leave room for register traffic during acceptance
  assign mach_cycle_en_o = (phase_reg[1:0] == 2'h3);
  assign instr_end_o     = (phase_reg == 4'hf) && !accept_busy_i;
endmodule : irq_cpu_model

`default_nettype wire

// ==== test/irq_latch_sva.sv ====
/*
  Checker for the interrupt unit: acceptance timing and APB answers.
  Assumes it is bound to the unit's top module, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module irq_latch_sva (
  input wire logic                                ref_clk_i,
  input wire logic                                rst_n_i,
  input wire logic                                psel_i,
  input wire logic                                penable_i,
  input wire logic                                pwrite_i,
  input wire logic [31:0]                         prdata_o,
  input wire logic                                pready_o,
  input wire logic                                pslverr_o,
  input wire logic [irq_latch_pkg::NUM_SRC-1:0]   src_request_i,
  input wire logic                                instr_end_i,
  input wire logic                                mach_cycle_en_i,
  input wire logic                                irq_request_o,
  input wire logic                                accept_busy_o,
  input wire logic                                accept_done_o
);
  import irq_latch_pkg::*;
  logic [3:0] mcyc_reg;

  // Machine cycles seen since the sequence began
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) mcyc_reg <= 4'h0;
    else if (!accept_busy_o) mcyc_reg <= 4'h0;
    else if (mach_cycle_en_i) mcyc_reg <= mcyc_reg + 4'h1;
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_start; instr_end_i && irq_request_o && !accept_busy_o |=> accept_busy_o; endproperty
  a_start: assert property (p_start) else $error("acceptance not started");
  property p_done12; accept_done_o |-> mach_cycle_en_i && mcyc_reg == 4'hb; endproperty
  a_done12: assert property (p_done12) else $error("done off count");
  property p_due; accept_busy_o && mach_cycle_en_i && mcyc_reg == 4'hb |-> accept_done_o; endproperty
  a_due: assert property (p_due) else $error("done missing");
  property p_ends; accept_done_o |=> !accept_busy_o; endproperty
  a_ends: assert property (p_ends) else $error("busy after done");
  property p_holds; accept_busy_o && !accept_done_o |=> accept_busy_o; endproperty
  a_holds: assert property (p_holds) else $error("busy dropped early");
  property p_wdt; src_request_i[SRC_WATCHDOG] |=> irq_request_o; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog not requested");
  property p_err; pslverr_o |-> psel_i && penable_i; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_zero; psel_i && penable_i && !pwrite_i && pslverr_o |=> prdata_o == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("refused read not zero");
  property p_rdy; psel_i && penable_i |-> pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");

  c_done: cover property (accept_done_o);
  c_wdt_busy: cover property (src_request_i[SRC_WATCHDOG] && accept_busy_o);
  c_err: cover property (psel_i && penable_i && pslverr_o);
endmodule : irq_latch_sva

bind nested_interrupt_latch_enable_unit irq_latch_sva u_sva (.ref_clk_i, .rst_n_i, .psel_i,
  .penable_i, .pwrite_i, .prdata_o, .pready_o, .pslverr_o, .src_request_i, .instr_end_i,
  .mach_cycle_en_i, .irq_request_o, .accept_busy_o, .accept_done_o);

`default_nettype wire

// ==== test/nested_interrupt_latch_enable_unit_tb.sv ====
/*
  Directed bench: APB register tasks, request pulses, returns.
  Assumes the CPU model drives strobes; software request tied off.
*/
`timescale 1ns/1ps
`default_nettype none

module nested_interrupt_latch_enable_unit_tb;
  import irq_latch_pkg::*;
  logic              ref_clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              psel_i = 1'b0;
  logic              penable_i = 1'b0;
  logic              pwrite_i = 1'b0;
  logic [11:0]       paddr_i = 12'h0;
  logic [31:0]       pwdata_i = 32'h0;
  logic [NUM_SRC-1:0] src_request_i = 40'h0;
  logic              unmask_all_instr_i = 1'b0;
  logic              mask_all_instr_i = 1'b0;
  logic              maskable_return_i = 1'b0;
  logic              nonmaskable_return_i = 1'b0;
  wire logic         instr_end_i, mach_cycle_en_i, pready_o, pslverr_o, irq_request_o;
  wire logic         accept_busy_o, accept_done_o, saved_master_o;
  wire logic [31:0]  prdata_o;
  wire logic [5:0]   accept_src_o;
  int                err_total = 0;
  int                checks_done = 0;
  int                cyc = 0;

  nested_interrupt_latch_enable_unit u_dut (.ref_clk_i, .rst_n_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i(4'hf), .prdata_o, .pready_o, .pslverr_o,
    .src_request_i, .software_request_i(1'b0), .instr_end_i, .mach_cycle_en_i,
    .unmask_all_instr_i, .mask_all_instr_i, .maskable_return_i, .nonmaskable_return_i,
    .irq_request_o, .accept_busy_o, .accept_done_o, .accept_src_o, .saved_master_o);
  irq_cpu_model u_cpu (.ref_clk_i, .rst_n_i, .accept_busy_i(accept_busy_o),
    .mach_cycle_en_o(mach_cycle_en_i), .instr_end_o(instr_end_i));

  always #4 ref_clk_i = ~ref_clk_i;

  task automatic final_report();
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  // Hang guard: run needs well under two thousand cycles
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  // Read data is registered, so it is taken one edge after the access
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= {2'h0, idx, 2'h0};
    pwdata_i <= {24'h0, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    @(posedge ref_clk_i);
    while (pready_o !== 1'b1) @(posedge ref_clk_i);
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge ref_clk_i);
    r = prdata_o;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 8'h0, r, e);
    chk("reg", {24'h0, exp}, r);
  endtask : rd

  // One-cycle pulses on request lines and instruction strobes
  task automatic kick(input logic [39:0] s, input logic [3:0] c);
    @(posedge ref_clk_i);
    src_request_i <= s;
    {mask_all_instr_i, unmask_all_instr_i, maskable_return_i, nonmaskable_return_i} <= c;
    @(posedge ref_clk_i);
    src_request_i <= 40'h0;
    {mask_all_instr_i, unmask_all_instr_i, maskable_return_i, nonmaskable_return_i} <= 4'h0;
  endtask : kick

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    while (accept_busy_o !== lvl && n < 300) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk("busy", {31'h0, lvl}, {31'h0, accept_busy_o});
  endtask : wait_busy

  initial begin : main
    logic [7:0] regs [10] = '{IDX_ENABLE_BYTE_E, IDX_LATCH_BYTE_C, IDX_ENABLE_BYTE_C,
      IDX_ENABLE_BYTE_D, IDX_LATCH_BYTE_E, IDX_LATCH_BYTE_D, IDX_ENABLE_LOW_MASTER,
      IDX_ENABLE_HIGH_BYTE, IDX_LATCH_LOW_BYTE, IDX_LATCH_HIGH_NESTING};
    logic [31:0] r;
    logic e;
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    apb(1'b0, 8'h10, 8'h00, r, e);
    chk("slverr", 32'h1, {31'h0, e});
    chk("unmapped", 32'h0, r);
    // Enables written with master off, by plain loads
    wr(8'h3b, 8'ha5);
    rd(8'h3b, 8'ha5);
    wr(8'h3a, 8'hf8);
    rd(8'h3a, 8'hf8);
    kick(40'h300, 3'h0);
    @(posedge ref_clk_i);
    chk("irq_off", 32'h0, {31'h0, irq_request_o});
    rd(8'h3d, 8'h03);
    wr(8'h3d, 8'hfe);
    rd(8'h3d, 8'h02);
    kick(40'h0, 3'h4);
    @(posedge ref_clk_i);
    chk("irq_dis", 32'h0, {31'h0, irq_request_o});
    rd(8'h3a, 8'hf9);
    kick(40'h2400, 3'h0);
    wait_busy(1'b1);
    chk("src", 32'd10, {26'h0, accept_src_o});
    chk("saved", 32'h1, {31'h0, saved_master_o});
    rd(8'h3a, 8'hf8);
    kick(40'h4, 3'h0);
    wr(8'h3c, 8'h00);
    rd(8'h3c, 8'h04);
    rd(8'h3d, 8'h62);
    wait_busy(1'b0);
    wait_busy(1'b1);
    chk("src", 32'd2, {26'h0, accept_src_o});
    chk("saved", 32'h0, {31'h0, saved_master_o});
    wait_busy(1'b0);
    rd(8'h3d, 8'ha2);
    kick(40'h0, 3'h1);
    rd(8'h3a, 8'hf8);
    rd(8'h3d, 8'h62);
    kick(40'h0, 3'h2);
    wait_busy(1'b1);
    chk("src", 32'd13, {26'h0, accept_src_o});
    wait_busy(1'b0);
    rd(8'h3d, 8'h42);
    wr(8'h3d, 8'hbf);
    rd(8'h3d, 8'h02);
    wr(8'h3d, 8'hbf);
    rd(8'h3d, 8'hc2);
    wr(8'h3d, 8'hff);
    rd(8'h3d, 8'hc2);
    wr(8'h3d, 8'h7f);
    rd(8'h3d, 8'h02);
    // Watchdog taken with master on: its return must restore master
    kick(40'h0, 4'h4);
    kick(40'h4, 4'h0);
    wait_busy(1'b1);
    chk("saved", 32'h1, {31'h0, saved_master_o});
    wait_busy(1'b0);
    rd(8'h3a, 8'hf8);
    kick(40'h0, 4'h1);
    rd(8'h3a, 8'hf9);
    kick(40'h0, 4'h8);
    rd(8'h3a, 8'hf8);
    final_report();
  end
endmodule : nested_interrupt_latch_enable_unit_tb

`default_nettype wire
